// *** rtl/tmcc_pkg.sv ***
// Constants, field layout and types shared by the timer channel files
package tmcc_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int          TMCC_DATA_W = 16;                   // Counter and data width
	localparam int          TMCC_ADDR_W = 4;                    // Register address width

	// ************************************************************
	// Register offsets (word index on the register port)
	// ************************************************************
	localparam logic [3:0]  ADDR_COUNT  = 4'h0;                 // Up-counter, read only
	localparam logic [3:0]  ADDR_CCR0   = 4'h1;                 // First capture/compare
	localparam logic [3:0]  ADDR_CCR1   = 4'h2;                 // Second capture/compare
	localparam logic [3:0]  ADDR_MODE   = 4'h3;                 // Mode control
	localparam logic [3:0]  ADDR_CAPCMP = 4'h4;                 // Capture/compare control
	localparam logic [3:0]  ADDR_OUTCTL = 4'h5;                 // Output control
	localparam logic [3:0]  ADDR_PRESC  = 4'h6;                 // Prescaler mode

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] COUNT_RESET = 16'h0000;             // Counter after reset
	localparam logic [15:0] CCR_RESET   = 16'h0000;             // Capture/compare after reset
	localparam logic [7:0]  CTRL_RESET  = 8'h00;                // Control registers after reset
	localparam logic [2:0]  DIV_RESET   = 3'h0;                 // Prescaler divider after reset

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int          MODE_OP_LO       = 2;               // Op mode select, low bit
	localparam int          MODE_OP_HI       = 3;               // Op mode select, high bit
	localparam int          CAPCMP_FN0       = 0;               // First reg: 1 capture, 0 compare
	localparam int          CAPCMP_SRC0      = 1;               // First reg trigger: 1 input a
	localparam int          CAPCMP_FN1       = 2;               // Second reg: 1 capture
	localparam int          OUTCTL_ENABLE    = 0;               // Output controller enable
	localparam int          OUTCTL_INV0      = 1;               // Toggle on first match
	localparam int          OUTCTL_INV1      = 2;               // Toggle on second match
	localparam int          OUTCTL_LEVEL     = 3;               // Idle output level
	localparam int          OUTCTL_ONESHOT_EN = 5;              // One-shot pulse mode enable
	localparam int          OUTCTL_ONESHOT_TRIG = 6;            // One-shot trigger, self clearing
	localparam int          PRESC_CLK_LO     = 0;               // Count clock select, 2 bits
	localparam int          PRESC_A_LO       = 4;               // Input a edge select, 2 bits
	localparam int          PRESC_B_LO       = 6;               // Input b edge select, 2 bits

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0] {
		TMCC_STOP      = 2'b00,                                 // Stopped, counter held at zero
		TMCC_FREE      = 2'b01,                                 // Free running
		TMCC_EDGE_CLR  = 2'b10,                                 // Clear and restart on input a
		TMCC_MATCH_CLR = 2'b11                                  // Clear and restart on match
	} tmcc_mode_t;

	localparam logic [1:0]  EDGE_FALL   = 2'b00;                // Falling edge valid
	localparam logic [1:0]  EDGE_RISE   = 2'b01;                // Rising edge valid
	localparam logic [1:0]  EDGE_BOTH   = 2'b11;                // Both edges valid

	localparam logic [1:0]  CLK_DIV1    = 2'b00;                // Count every core clock
	localparam logic [1:0]  CLK_DIV2    = 2'b01;                // Count every second clock
	localparam logic [1:0]  CLK_DIV4    = 2'b10;                // Count every fourth clock
	localparam logic [1:0]  CLK_EXT     = 2'b11;                // Count valid edges of input a

	// Picks the valid (or opposite) edge from a two bit select
	function automatic logic tmcc_edge_pick(input logic [1:0] sel, input logic rise,
		input logic fall, input logic opposite);
		logic hit;
		hit = 1'b0;
		if (sel == EDGE_FALL) begin
			hit = opposite ? rise : fall;
		end else if (sel == EDGE_RISE) begin
			hit = opposite ? fall : rise;
		end else if (sel == EDGE_BOTH) begin
			hit = opposite ? 1'b0 : (rise | fall);
		end
		return hit;
	endfunction : tmcc_edge_pick

endpackage : tmcc_pkg

// *** rtl/tmcc_edge.sv ***
// Edge detector for one timer input pin with programmable valid edge
`timescale 1ns/100ps

module tmcc_edge
	import tmcc_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Pin and select
	input  wire logic       pin,
	input  wire logic [1:0] sel,
	// Detected edges
	output logic            valid_edge,
	output logic            opposite_edge
);

	// ************************************************************
	// Edge detection
	// ************************************************************
	logic pin_prev;                                             // Pin level one clock ago
	logic rise;                                                 // Low to high this clock
	logic fall;                                                 // High to low this clock

	// Previous level; pin is already synchronous to core_clk
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= pin;
		end
	end

	assign rise          = pin & ~pin_prev;
	assign fall          = ~pin & pin_prev;
	// Select code 10 is forbidden and simply detects nothing
	assign valid_edge    = tmcc_edge_pick(sel, rise, fall, 1'b0);
	assign opposite_edge = tmcc_edge_pick(sel, rise, fall, 1'b1);

endmodule : tmcc_edge

// *** rtl/tmcc_timer.sv ***
// One channel of the 16-bit timer/event counter with capture/compare
`timescale 1ns/100ps

module tmcc_timer
	import tmcc_pkg::*;
#(
	parameter int DATA_W = TMCC_DATA_W,                         // Counter width
	parameter int ADDR_W = TMCC_ADDR_W                          // Register address width
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Timer pins
	input  wire logic              timer_input_a,
	input  wire logic              timer_input_b,
	output logic                   timer_output_pin,
	// Interrupt requests
	output logic                   first_compare_irq,
	output logic                   second_compare_irq
);

	// ************************************************************
	// Register file
	// ************************************************************
	logic [DATA_W-1:0] up_counter;                              // Live count
	logic [DATA_W-1:0] capture_compare_first;                   // First capture/compare
	logic [DATA_W-1:0] capture_compare_second;                  // Second capture/compare
	logic [7:0]        mode_control_register;                   // Op mode bits
	logic [7:0]        capcmp_control_register;                 // Function and source
	logic [7:0]        output_control_register;                 // Output controller
	logic [7:0]        prescaler_mode_register;                 // Clock and edge select

	logic wr_ccr0;                                              // Write strobe, first reg
	logic wr_ccr1;                                              // Write strobe, second reg
	logic one_shot_trigger_bit;                                 // Pulse from trigger write

	assign wr_ccr0 = reg_wr && (reg_addr == ADDR_CCR0);
	assign wr_ccr1 = reg_wr && (reg_addr == ADDR_CCR1);
	assign one_shot_trigger_bit = reg_wr && (reg_addr == ADDR_OUTCTL)
		&& reg_wdata[OUTCTL_ONESHOT_TRIG];

	// Control registers; trigger bit is not stored and reads zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_control_register   <= CTRL_RESET;
			capcmp_control_register <= CTRL_RESET;
			output_control_register <= CTRL_RESET;
			prescaler_mode_register <= CTRL_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_MODE) begin
				mode_control_register   <= reg_wdata[7:0];
			end else if (reg_addr == ADDR_CAPCMP) begin
				capcmp_control_register <= reg_wdata[7:0];
			end else if (reg_addr == ADDR_OUTCTL) begin
				output_control_register <= reg_wdata[7:0] & ~(8'h01 << OUTCTL_ONESHOT_TRIG);
			end else if (reg_addr == ADDR_PRESC) begin
				prescaler_mode_register <= reg_wdata[7:0];
			end
		end
	end

	// ************************************************************
	// Decoded control
	// ************************************************************
	tmcc_mode_t mode;                                           // Operating mode
	logic       running;                                        // Any mode but stop
	logic       first_is_capture;                               // First reg captures
	logic       second_is_capture;                              // Second reg captures
	logic       one_shot_mode;                                  // One-shot pulse output
	logic [1:0] input_a_edge_sel;                               // Valid edge of input a
	logic [1:0] input_b_edge_sel;                               // Valid edge of input b
	logic [1:0] clk_sel;                                        // Count clock select

	assign mode = tmcc_mode_t'(mode_control_register[MODE_OP_HI:MODE_OP_LO]);
	assign running = (mode != TMCC_STOP);
	assign first_is_capture  = capcmp_control_register[CAPCMP_FN0];
	assign second_is_capture = capcmp_control_register[CAPCMP_FN1];
	assign one_shot_mode = output_control_register[OUTCTL_ONESHOT_EN]
		&& (mode == TMCC_FREE || mode == TMCC_EDGE_CLR);
	assign input_a_edge_sel = prescaler_mode_register[PRESC_A_LO+1:PRESC_A_LO];
	assign input_b_edge_sel = prescaler_mode_register[PRESC_B_LO+1:PRESC_B_LO];
	assign clk_sel = prescaler_mode_register[PRESC_CLK_LO+1:PRESC_CLK_LO];

	// ************************************************************
	// Input pin edges
	// ************************************************************
	logic a_valid;                                              // Valid edge on input a
	logic a_opposite;                                           // Opposite edge on input a
	logic b_valid;                                              // Valid edge on input b

	tmcc_edge u_edge_a (
		.core_clk      (core_clk),
		.rst           (rst),
		.pin           (timer_input_a),
		.sel           (input_a_edge_sel),
		.valid_edge    (a_valid),
		.opposite_edge (a_opposite)
	);

	tmcc_edge u_edge_b (
		.core_clk      (core_clk),
		.rst           (rst),
		.pin           (timer_input_b),
		.sel           (input_b_edge_sel),
		.valid_edge    (b_valid),
		.opposite_edge ()
	);

	// ************************************************************
	// Count clock
	// ************************************************************
	logic [2:0] div_cnt;                                        // Prescaler divider
	logic       tick;                                           // Count pulse this clock

	// Divider restarts on stop so the first count is a full period
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= DIV_RESET;
		end else if (!running) begin
			div_cnt <= DIV_RESET;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	// External event counting uses input a edges as the clock
	always_comb begin
		tick = 1'b0;
		if (!running) begin
			tick = 1'b0;
		end else if (clk_sel == CLK_DIV1) begin
			tick = 1'b1;
		end else if (clk_sel == CLK_DIV2) begin
			tick = div_cnt[0];
		end else if (clk_sel == CLK_DIV4) begin
			tick = (div_cnt[1:0] == 2'h3);
		end else begin
			tick = a_valid;
		end
	end

	// ************************************************************
	// Counter
	// ************************************************************
	logic eq0;                                                  // Counter equals first reg
	logic eq1;                                                  // Counter equals second reg
	logic edge_clear;                                           // Immediate clear request
	logic match_clear;                                          // Clear at next count

	assign eq0 = (up_counter == capture_compare_first);
	assign eq1 = (up_counter == capture_compare_second);
	assign edge_clear = running && (((mode == TMCC_EDGE_CLR) && a_valid)
		|| (one_shot_mode && (one_shot_trigger_bit || a_valid)));
	assign match_clear = (mode == TMCC_MATCH_CLR) && !first_is_capture && eq0;

	// Stop wins, then edge or trigger clear, then the count pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			up_counter <= COUNT_RESET;
		end else if (!running) begin
			up_counter <= COUNT_RESET;
		end else if (edge_clear) begin
			up_counter <= COUNT_RESET;
		end else if (tick && match_clear) begin
			up_counter <= COUNT_RESET;
		end else if (tick) begin
			up_counter <= up_counter + 16'h0001;
		end
	end

	// ************************************************************
	// Capture and compare registers
	// ************************************************************
	logic cap0;                                                 // Capture into first reg
	logic cap1;                                                 // Capture into second reg

	// First reg: input a path uses the opposite edge, input b its own valid edge; second reg: valid edge of input a
	assign cap0 = running && first_is_capture
		&& (capcmp_control_register[CAPCMP_SRC0] ? a_opposite : b_valid);
	assign cap1 = running && second_is_capture && a_valid;

	// A capture in the cycle of a software write wins over the write
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			capture_compare_first <= CCR_RESET;
		end else if (cap0) begin
			capture_compare_first <= up_counter;
		end else if (wr_ccr0) begin
			capture_compare_first <= reg_wdata;
		end
	end

	// Second register mirrors the first with the valid edge of input a as trigger
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			capture_compare_second <= CCR_RESET;
		end else if (cap1) begin
			capture_compare_second <= up_counter;
		end else if (wr_ccr1) begin
			capture_compare_second <= reg_wdata;
		end
	end

	// ************************************************************
	// Compare requests
	// ************************************************************
	logic hit0;                                                 // Qualified first match
	logic hit1;                                                 // Qualified second match
	logic hit0_d;                                               // First match last clock
	logic hit1_d;                                               // Second match last clock

	assign hit0 = running && !first_is_capture && eq0;
	assign hit1 = running && !second_is_capture && eq1;

	// One request per arrival at the match, not one per clock held
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hit0_d             <= 1'b0;
			hit1_d             <= 1'b0;
			first_compare_irq  <= 1'b0;
			second_compare_irq <= 1'b0;
		end else begin
			hit0_d             <= hit0;
			hit1_d             <= hit1;
			first_compare_irq  <= hit0 && !hit0_d;
			second_compare_irq <= hit1 && !hit1_d;
		end
	end

	// ************************************************************
	// Output controller
	// ************************************************************
	// Idle level while disabled or stopped; toggles give square and PWM
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timer_output_pin <= 1'b0;
		end else if (!running || !output_control_register[OUTCTL_ENABLE]) begin
			timer_output_pin <= output_control_register[OUTCTL_LEVEL];
		end else if ((hit0 && !hit0_d && output_control_register[OUTCTL_INV0])
			!= (hit1 && !hit1_d && output_control_register[OUTCTL_INV1])) begin
			timer_output_pin <= ~timer_output_pin;
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	// Data stand one clock after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (!reg_rd) begin
			reg_rdata <= 16'h0000;
		end else if (reg_addr == ADDR_COUNT) begin
			reg_rdata <= up_counter;
		end else if (reg_addr == ADDR_CCR0) begin
			reg_rdata <= capture_compare_first;
		end else if (reg_addr == ADDR_CCR1) begin
			reg_rdata <= capture_compare_second;
		end else if (reg_addr == ADDR_MODE) begin
			reg_rdata <= {8'h00, mode_control_register};
		end else if (reg_addr == ADDR_CAPCMP) begin
			reg_rdata <= {8'h00, capcmp_control_register};
		end else if (reg_addr == ADDR_OUTCTL) begin
			reg_rdata <= {8'h00, output_control_register};
		end else if (reg_addr == ADDR_PRESC) begin
			reg_rdata <= {8'h00, prescaler_mode_register};
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_stopped_two;
		!running ##1 !running;
	endsequence

	sequence s_plain_count;
		running && tick && !edge_clear && !match_clear;
	endsequence

	property p_stop_clears;
		@(posedge core_clk) disable iff (rst) !running |=> (up_counter == 16'h0000);
	endproperty
	a_stop_clears: assert property (p_stop_clears)
		else $error("counter not zero while stopped");

	property p_count_inc;
		@(posedge core_clk) disable iff (rst)
			s_plain_count |=> (up_counter == $past(up_counter) + 16'h0001);
	endproperty
	a_count_inc: assert property (p_count_inc)
		else $error("counter did not advance by one");

	property p_edge_clear;
		@(posedge core_clk) disable iff (rst)
			(mode == TMCC_EDGE_CLR) && a_valid ##1 running |-> (up_counter == 16'h0000);
	endproperty
	a_edge_clear: assert property (p_edge_clear)
		else $error("input edge did not clear counter");

	property p_match_clear;
		@(posedge core_clk) disable iff (rst)
			running && tick && match_clear ##1 running |-> (up_counter == 16'h0000);
	endproperty
	a_match_clear: assert property (p_match_clear)
		else $error("match did not clear counter");

	property p_one_shot;
		@(posedge core_clk) disable iff (rst)
			one_shot_mode && one_shot_trigger_bit |=> (up_counter == 16'h0000);
	endproperty
	a_one_shot: assert property (p_one_shot)
		else $error("one-shot trigger did not clear counter");

	property p_irq;
		@(posedge core_clk) disable iff (rst)
			(running && !first_is_capture && eq0 && !hit0_d) |=> first_compare_irq ##1 !first_compare_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("compare request missing or too long");

	property p_capture;
		@(posedge core_clk) disable iff (rst) cap0 |=> (capture_compare_first == $past(up_counter));
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value wrong");

	property p_hold;
		@(posedge core_clk) disable iff (rst)
			!first_is_capture && !wr_ccr0 |=> $stable(capture_compare_first);
	endproperty
	a_hold: assert property (p_hold)
		else $error("compare value changed without a write");

	property p_stopped_quiet;
		@(posedge core_clk) disable iff (rst) s_stopped_two |-> !first_compare_irq && !cap0;
	endproperty
	a_stopped_quiet: assert property (p_stopped_quiet)
		else $error("request or capture while stopped");

	property p_read_count;
		@(posedge core_clk) disable iff (rst)
			reg_rd && (reg_addr == ADDR_COUNT) |=> (reg_rdata == $past(up_counter));
	endproperty
	a_read_count: assert property (p_read_count)
		else $error("counter readback wrong");

endmodule : tmcc_timer

// *** test/tmcc_pins.sv ***
// Behavioural model of the two external trigger pins
`timescale 1ns/100ps

module tmcc_pins (
	// Clock and requests
	input  wire logic core_clk,
	input  wire logic tog_a,
	input  wire logic tog_b,
	// Pin levels
	output logic      timer_input_a,
	output logic      timer_input_b
);
	// Pins start low and flip on request, as an external source would
	initial begin
		timer_input_a = 1'b0;
		timer_input_b = 1'b0;
	end
	// Flip on the edge after a request, one pin each
	always @(posedge core_clk) begin
		if (tog_a) timer_input_a <= ~timer_input_a;
		if (tog_b) timer_input_b <= ~timer_input_b;
	end
endmodule : tmcc_pins

// *** test/testbench.sv ***
// Self-checking bench for the timer channel
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
	import tmcc_pkg::*;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, c1, c2;
	logic        tog_a = 1'b0, tog_b = 1'b0, timer_input_a, timer_input_b;
	logic        timer_output_pin, first_compare_irq, second_compare_irq;
	int          failures = 0, n_tests = 0, cycles = 0, k, j;

	always #5 core_clk = ~core_clk;
	tmcc_pins pins (.core_clk(core_clk), .tog_a(tog_a), .tog_b(tog_b),
		.timer_input_a(timer_input_a), .timer_input_b(timer_input_b));
	tmcc_timer dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
		.timer_output_pin(timer_output_pin), .first_compare_irq(first_compare_irq),
		.second_compare_irq(second_compare_irq));

	// ************************************************************
	// Bus and pin tasks
	// ************************************************************
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge core_clk); reg_wr <= 1'b0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge core_clk); reg_rd <= 1'b1; reg_addr <= a;
		@(posedge core_clk); reg_rd <= 1'b0;
		@(negedge core_clk); v = reg_rdata;
	endtask : rd
	task automatic tg(input logic use_a);
		@(posedge core_clk); tog_a <= use_a; tog_b <= ~use_a;
		@(posedge core_clk); tog_a <= 1'b0; tog_b <= 1'b0;
	endtask : tg
	task automatic irqs(input int n, output int m);
		m = 0;
		repeat (n) begin @(negedge core_clk); if (first_compare_irq === 1'b1) m++; end
	endtask : irqs
	// Counts output pin changes and second requests over n settled clocks
	task automatic outs(input int n, output int m, output int q);
		logic p;
		m = 0; q = 0;
		@(negedge core_clk); p = timer_output_pin;
		repeat (n) begin
			@(negedge core_clk); if (timer_output_pin !== p) m++;
			p = timer_output_pin; if (second_compare_irq === 1'b1) q++;
		end
	endtask : outs

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		rd(ADDR_COUNT, c1); `CHK(c1, COUNT_RESET)
		rd(ADDR_CCR0, c1); `CHK(c1, CCR_RESET)
		rd(4'hf, c1); `CHK(c1, 16'h0000)
		$display("test reset done");
	endtask : t_reset
	// Period of four counts, so a 40 cycle window holds ten requests
	task automatic t_match();
		wr(ADDR_CCR0, 16'h0003);
		wr(ADDR_MODE, 16'h000c);
		repeat (10) @(posedge core_clk);
		irqs(40, k); `CHK(k, 10)
		rd(ADDR_CCR0, c1); `CHK(c1, 16'h0003)
		rd(ADDR_COUNT, c1); `CHK(c1 <= 16'h0003, 1'b1)
		$display("test match done");
	endtask : t_match
	task automatic t_stop();
		wr(ADDR_MODE, 16'h0000);
		wr(ADDR_COUNT, 16'h1234);
		rd(ADDR_COUNT, c1); `CHK(c1, 16'h0000)
		irqs(20, k); `CHK(k, 0)
		$display("test stop done");
	endtask : t_stop
	// Pin flips at 0, 10, 30, 40 cycles; both captures lie 30 apart
	task automatic t_cap(input logic use_a, input logic [15:0] ctl, input logic [15:0] pre);
		wr(ADDR_PRESC, pre);
		wr(ADDR_CAPCMP, ctl);
		wr(ADDR_MODE, 16'h0004);
		tg(use_a); repeat (8) @(posedge core_clk); tg(use_a);
		repeat (4) @(posedge core_clk); rd(ADDR_CCR0, c1);
		repeat (12) @(posedge core_clk); tg(use_a);
		repeat (8) @(posedge core_clk); tg(use_a);
		repeat (4) @(posedge core_clk); rd(ADDR_CCR0, c2);
		`CHK(c2 - c1, 16'd30)
		wr(ADDR_MODE, 16'h0000);
		$display("test capture done");
	endtask : t_cap

	// Edge clear in mode 10, then one-shot trigger in free run
	task automatic t_clr();
		wr(ADDR_PRESC, 16'h0010); wr(ADDR_CAPCMP, 16'h0000);
		wr(ADDR_MODE, 16'h0008); repeat (20) @(posedge core_clk);
		rd(ADDR_COUNT, c2); `CHK(c2 > 16'h000f, 1'b1)
		tg(1'b1); rd(ADDR_COUNT, c1); `CHK(c1 < 16'h0003, 1'b1)
		wr(ADDR_MODE, 16'h0004); wr(ADDR_OUTCTL, 16'h0020);
		repeat (20) @(posedge core_clk);
		wr(ADDR_OUTCTL, 16'h0060); rd(ADDR_COUNT, c1); `CHK(c1 < 16'h0003, 1'b1)
		rd(ADDR_OUTCTL, c1); `CHK(c1, 16'h0020)
		wr(ADDR_MODE, 16'h0000); wr(ADDR_OUTCTL, 16'h0000);
		$display("test clear done");
	endtask : t_clr
	// Idle level, toggling output and second request, then half count rate
	task automatic t_out();
		wr(ADDR_CCR0, 16'h0003); wr(ADDR_CCR1, 16'h0002);
		wr(ADDR_OUTCTL, 16'h000b); repeat (2) @(negedge core_clk);
		`CHK(timer_output_pin, 1'b1)
		wr(ADDR_MODE, 16'h000c); repeat (10) @(posedge core_clk);
		outs(40, k, j); `CHK(k, 10)
		`CHK(j, 10)
		wr(ADDR_PRESC, 16'h0011); repeat (10) @(posedge core_clk);
		irqs(40, k); `CHK(k, 5)
		wr(ADDR_MODE, 16'h0000); repeat (2) @(negedge core_clk);
		`CHK(timer_output_pin, 1'b1)
		$display("test output done");
	endtask : t_out

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin failures++; print_verdict(); end
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset(); t_match(); t_stop();
		t_cap(1'b0, 16'h0001, 16'h0040);
		t_cap(1'b1, 16'h0003, 16'h0010);
		t_clr(); t_out();
		print_verdict();
	end
endmodule : testbench
